// ==== logic/bank_select.sv ====
// Page register with save/restore slots for one paged module.
// Assumes Avalon-MM master; paged module registers sit behind mod_* ports.
`timescale 1ns/1ps
// Function
// - 3-bit page field, write selects, read returns
// - Paged accesses routed by stored page
// - Four slots picked by 2-bit index
// - Action 0x writes page directly
// - Action 10 saves old page, loads new
// - Action 11 restores page from slot
// - Bit 3 reserved, reads zero
// - Reset clears register, page zero active
// - One instance per paged module
module bank_select (
  input  wire logic                                    sys_clk_i,
  input  wire logic                                    rst_n_i,
  input  wire logic                                    ce_i,
  input  wire logic [bank_select_pkg::ADDR_W-1:0]      avs_address_i,
  input  wire logic                                    avs_read_i,
  input  wire logic                                    avs_write_i,
  input  wire logic [bank_select_pkg::DATA_W-1:0]      avs_writedata_i,
  input  wire logic [3:0]                              avs_byteenable_i,
  output logic      [bank_select_pkg::DATA_W-1:0]      avs_readdata_o,
  output logic                                         avs_waitrequest_o,
  output logic      [bank_select_pkg::PAGE_W-1:0]      page_o,
  output logic                                         mod_read_o,
  output logic                                         mod_write_o,
  output logic      [bank_select_pkg::PAGE_W-1:0]      module_bank_select_reg_o,
  output logic      [3:0]                              mod_reg_o,
  output logic      [bank_select_pkg::MOD_DATA_W-1:0]  mod_wdata_o,
  input  wire logic [bank_select_pkg::MOD_DATA_W-1:0]  mod_rdata_i
);
  // One-hot handshake states; paged reads spend one extra cycle fetching
  typedef enum logic [2:0] {
    ST_IDLE  = 3'h1,
    ST_FETCH = 3'h2,
    ST_ANS   = 3'h4
  } bus_state_t;

  typedef struct packed {
    bus_state_t                             st;
    logic [bank_select_pkg::PAGE_W-1:0]     page;
    logic [bank_select_pkg::DATA_W-1:0]     rdata;
    logic                                   mrd;
    logic                                   mwr;
    logic [bank_select_pkg::PAGE_W-1:0]     mpage;
    logic [bank_select_pkg::REG_W-1:0]      mreg;
    logic [bank_select_pkg::MOD_DATA_W-1:0] mwdata;
  } state_t;

  localparam logic [bank_select_pkg::PAGE_W-1:0] RESET_PAGE =
    bank_select_pkg::RESET_VAL[bank_select_pkg::PAGE_LSB +: bank_select_pkg::PAGE_W];
  // All-zero would be no legal one-hot state, so reset names the idle state
  localparam state_t RESET_STATE = '{
    st:      ST_IDLE,
    page:    RESET_PAGE,
    default: '0
  };

  state_t s_q;
  state_t s_d;

  logic                                   req;
  logic                                   hit_sel;
  logic                                   hit_paged;
  logic                                   wr_sel;
  logic                                   do_save;
  logic                                   do_restore;
  logic [bank_select_pkg::ACT_W-1:0]      act;
  logic [bank_select_pkg::SLOT_W-1:0]     slot;
  logic [bank_select_pkg::PAGE_W-1:0]     new_page;
  logic [bank_select_pkg::PAGE_W-1:0]     slot_page;
  logic [bank_select_pkg::DATA_W-1:0]     sel_word;
  logic [bank_select_pkg::DATA_W-1:0]     mod_word;

  // Held strobe is ignored while answering, so one request is taken once
  assign req        = (avs_read_i || avs_write_i) && (s_q.st == ST_IDLE);
  assign hit_sel    = (avs_address_i == bank_select_pkg::BANK_SEL_ADDR);
  assign hit_paged  = ((avs_address_i & bank_select_pkg::PAGED_MASK)
                       == bank_select_pkg::PAGED_BASE);
  // Writes without the low byte lane are dropped
  assign wr_sel     = ce_i && req && avs_write_i && hit_sel && avs_byteenable_i[0];
  assign act        = avs_writedata_i[bank_select_pkg::ACT_LSB +: bank_select_pkg::ACT_W];
  assign slot       = avs_writedata_i[bank_select_pkg::SLOT_LSB +: bank_select_pkg::SLOT_W];
  assign new_page   = avs_writedata_i[bank_select_pkg::PAGE_LSB +: bank_select_pkg::PAGE_W];
  assign do_save    = wr_sel && (act == bank_select_pkg::ACT_SAVE);
  assign do_restore = wr_sel && (act == bank_select_pkg::ACT_RESTORE);
  assign mod_word   = {{(bank_select_pkg::DATA_W - bank_select_pkg::MOD_DATA_W){1'b0}},
                       mod_rdata_i};

  // Only the page field reads back; reserved and write-only bits read zero
  always_comb begin
    sel_word = '0;
    sel_word[bank_select_pkg::PAGE_LSB +: bank_select_pkg::PAGE_W] = s_q.page;
  end

  // One page register and slot store per paged module
  bank_slot_store u_slots (
    .sys_clk_i (sys_clk_i),
    .rst_n_i   (rst_n_i),
    .ce_i      (ce_i),
    .save_i    (do_save),
    .slot_i    (slot),
    .page_i    (s_q.page),
    .rd_page_o (slot_page)
  );

  always_comb begin
    s_d     = s_q;
    s_d.mrd = 1'b0;
    s_d.mwr = 1'b0;
    case (s_q.st)
      ST_IDLE: begin
        if (req) begin
          s_d.st    = ST_ANS;
          s_d.rdata = '0;
          if (hit_sel) begin
            s_d.rdata = sel_word;
          end
          if (do_save) begin
            // Slot store takes the old page on this same edge
            s_d.page = new_page;
          end else if (do_restore) begin
            s_d.page = slot_page;
          end else if (wr_sel) begin
            s_d.page = new_page;
          end
          if (hit_paged) begin
            // Page comes from the register, never from the address
            s_d.mpage  = s_q.page;
            s_d.mreg   = avs_address_i[bank_select_pkg::REG_LSB +: bank_select_pkg::REG_W];
            s_d.mwdata = avs_writedata_i[bank_select_pkg::MOD_DATA_W-1:0];
            s_d.mrd    = avs_read_i;
            s_d.mwr    = avs_write_i && avs_byteenable_i[0];
            if (avs_read_i) begin
              s_d.st = ST_FETCH;
            end
          end
        end
      end
      ST_FETCH: begin
        // Paged module drives its data while the read strobe stands
        s_d.rdata = mod_word;
        s_d.st    = ST_ANS;
      end
      ST_ANS: begin
        s_d.st = ST_IDLE;
      end
      default: begin
        s_d.st = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      s_q <= RESET_STATE;
    end else if (ce_i) begin
      s_q <= s_d;
    end
  end

  // Waitrequest drops only in the answer cycle
  assign avs_waitrequest_o = (s_q.st != ST_ANS);
  assign avs_readdata_o    = s_q.rdata;
  assign page_o            = s_q.page;
  assign mod_read_o        = s_q.mrd;
  assign mod_write_o       = s_q.mwr;
  assign module_bank_select_reg_o        = s_q.mpage;
  assign mod_reg_o         = s_q.mreg;
  assign mod_wdata_o       = s_q.mwdata;
endmodule

// ==== logic/bank_select_pkg.sv ====
// Package for the paged register bank selector.
// Assumes a single 100 MHz system clock and Avalon-MM register access.
package bank_select_pkg;
  localparam int unsigned PAGE_W      = 3;
  localparam int unsigned SLOT_W      = 2;
  localparam int unsigned NUM_SLOTS   = 4;
  localparam int unsigned ADDR_W      = 8;
  localparam int unsigned DATA_W      = 32;
  localparam int unsigned MOD_DATA_W  = 8;
  // Byte address of the page register; paged registers follow it
  localparam logic [7:0]  BANK_SEL_ADDR = 8'h00;
  localparam logic [7:0]  PAGED_BASE    = 8'h40;
  localparam logic [7:0]  PAGED_MASK    = 8'hc0;
  localparam logic [7:0]  RESET_VAL     = 8'h00;
  localparam int unsigned PAGE_LSB    = 0;
  localparam int unsigned SLOT_LSB    = 4;
  localparam int unsigned ACT_LSB     = 6;
  localparam int unsigned ACT_W       = 2;
  // Paged register number taken from the word address bits
  localparam int unsigned REG_LSB     = 2;
  localparam int unsigned REG_W       = 4;
  localparam logic [1:0]  ACT_SAVE    = 2'h2;
  localparam logic [1:0]  ACT_RESTORE = 2'h3;
endpackage

// ==== logic/bank_slot_store.sv ====
// Four save slots holding page numbers.
// Assumes writes are qualified by the caller's clock enable.
`timescale 1ns/1ps
module bank_slot_store (
  input  wire logic                                sys_clk_i,
  input  wire logic                                rst_n_i,
  input  wire logic                                ce_i,
  input  wire logic                                save_i,
  input  wire logic [bank_select_pkg::SLOT_W-1:0]  slot_i,
  input  wire logic [bank_select_pkg::PAGE_W-1:0]  page_i,
  output logic      [bank_select_pkg::PAGE_W-1:0]  rd_page_o
);
  typedef struct packed {
    logic [bank_select_pkg::NUM_SLOTS-1:0][bank_select_pkg::PAGE_W-1:0] slot;
  } state_t;
  state_t s_q;
  state_t s_d;

  always_comb begin
    s_d = s_q;
    for (int i = 0; i < bank_select_pkg::NUM_SLOTS; i++) begin
      // Only a save touches a slot
      if (save_i && (slot_i == i[bank_select_pkg::SLOT_W-1:0])) begin
        s_d.slot[i] = page_i;
      end
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      s_q <= '0;
    end else if (ce_i) begin
      s_q <= s_d;
    end
  end

  assign rd_page_o = s_q.slot[slot_i];
endmodule

// ==== testbench/bank_select_assertions.sv ====
// Checker for the page register: page loads, slot save/restore, routing.
// Bound to bank_select; sees only its ports, ce_i assumed high.
`timescale 1ns/1ps
module bank_select_assertions (
  input wire logic        sys_clk_i, rst_n_i, avs_write_i, avs_read_i, avs_waitrequest_o,
  input wire logic        mod_read_o,
  input wire logic [7:0]  avs_address_i, mod_rdata_i,
  input wire logic [31:0] avs_writedata_i, avs_readdata_o,
  input wire logic [3:0]  avs_byteenable_i,
  input wire logic [2:0]  page_o, module_bank_select_reg_o
);
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (!rst_n_i);
  logic [2:0] prev_q;
  logic [2:0] slot_q [4];
  wire wr0 = avs_write_i && !avs_waitrequest_o && avs_address_i == 8'h00 && avs_byteenable_i[0];
  wire [1:0] act = avs_writedata_i[7:6];
  wire [1:0] idx = avs_writedata_i[5:4];
  // Page seen at the answer edge is already new, so the old one is one sample back
  always_ff @(posedge sys_clk_i) begin
    prev_q <= page_o;
    if (!rst_n_i) slot_q <= '{default: 3'h0};
    else if (wr0 && act == 2'h2) slot_q[idx] <= prev_q;
  end
  property p_man; wr0 && act != 2'h3 |-> page_o == avs_writedata_i[2:0]; endproperty
  a_man: assert property (p_man) else $error("page not loaded");
  property p_rest; wr0 && act == 2'h3 |-> page_o == slot_q[idx]; endproperty
  a_rest: assert property (p_rest) else $error("restore wrong");
  property p_rst; disable iff (1'b0) !rst_n_i |=> page_o == 3'h0; endproperty
  a_rst: assert property (p_rst) else $error("page not cleared");
  property p_rd; avs_read_i && !avs_waitrequest_o && avs_address_i == 8'h00
    |-> avs_readdata_o == {29'h0000_0000, page_o}; endproperty
  a_rd: assert property (p_rd) else $error("readback wrong");
  property p_hold; $changed(page_o) |-> wr0; endproperty
  a_hold: assert property (p_hold) else $error("page moved");
  property p_route; mod_read_o |-> module_bank_select_reg_o == page_o; endproperty
  a_route: assert property (p_route) else $error("wrong page routed");
  property p_pdat; mod_read_o |=> !avs_waitrequest_o && avs_readdata_o[7:0] == $past(mod_rdata_i);
  endproperty
  a_pdat: assert property (p_pdat) else $error("paged data wrong");
  property p_one; mod_read_o |=> !mod_read_o; endproperty
  a_one: assert property (p_one) else $error("paged read repeated");
endmodule

// ==== testbench/bank_select_tb.sv ====
// Testbench for bank_select: page writes, save/restore, paged read, reset.
// Drives the Avalon-MM port itself; checker bound at the foot.
`timescale 1ns/1ps
module bank_select_tb;
  logic        sys_clk_i = 1'b0, rst_n_i = 1'b0, wr = 1'b0, rd = 1'b0, wrq;
  logic [7:0]  addr = 8'h00;
  logic [31:0] wdat = 32'h0000_0000, q, rdo;
  logic [3:0]  be = 4'hf, mreg_o;
  logic [2:0]  pg_o, mpg_o;
  logic [7:0]  mwd_o, mod_rd = 8'h5a;
  logic        mwr_o;
  logic [15:0] mq;
  int          num_errors = 0, check_count = 0;
  // Written byte beside the page it must leave active
  logic [15:0] rows [13] = '{16'h0505, 16'h4303, 16'h9707, 16'ha202, 16'hd003, 16'he507,
    16'h0000, 16'hb101, 16'h8404, 16'hf600, 16'hc001, 16'hd803, 16'h5f07};
  initial forever #5 sys_clk_i = ~sys_clk_i;
  bank_select u_dut (.sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .ce_i(1'b1),
    .avs_address_i(addr), .avs_read_i(rd), .avs_write_i(wr), .avs_writedata_i(wdat),
    .avs_byteenable_i(be), .avs_readdata_o(rdo), .avs_waitrequest_o(wrq), .page_o(pg_o),
    .mod_read_o(), .mod_write_o(mwr_o), .module_bank_select_reg_o(mpg_o), .mod_reg_o(mreg_o),
    .mod_wdata_o(mwd_o), .mod_rdata_i(mod_rd));
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    check_count++;
    if (g !== e) begin
      num_errors++;
      $display("unexpected %s: expected %h seen %h", n, e, g);
    end
  endtask
  // Called just after a rising edge; held until waitrequest is seen low, then one idle edge
  task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d);
    wr <= w;
    rd <= !w;
    addr <= a;
    wdat <= {24'h00_0000, d};
    do @(posedge sys_clk_i); while (wrq !== 1'b0);
    q = rdo;
    mq = {mwr_o, mpg_o, mreg_o, mwd_o};
    wr <= 1'b0;
    rd <= 1'b0;
    @(posedge sys_clk_i);
  endtask
  task automatic test_done();
    $display("checks %0d mismatches %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  initial begin
    repeat (3000) @(posedge sys_clk_i);
    num_errors++;
    test_done();
  end
  initial begin
    repeat (2) @(posedge sys_clk_i);
    rst_n_i <= 1'b1;
    bus(1'b0, 8'h00, 8'h00);
    chk("reset page", 32'h0000_0000, q);
    chk("reset page_o", 32'h0000_0000, {29'h0000_0000, pg_o});
    $display("reset test done");
    foreach (rows[i]) begin
      bus(1'b1, 8'h00, rows[i][15:8]);
      chk("page_o", {24'h00_0000, rows[i][7:0]}, {29'h0000_0000, pg_o});
      bus(1'b0, 8'h00, 8'h00);
      chk("page", {24'h00_0000, rows[i][7:0]}, q);
    end
    $display("table rows done");
    be <= 4'he;
    bus(1'b1, 8'h00, 8'h01);
    be <= 4'hf;
    bus(1'b0, 8'h00, 8'h00);
    chk("masked write", 32'h0000_0007, q);
    bus(1'b1, 8'h80, 8'h05);
    bus(1'b0, 8'h00, 8'h00);
    chk("unmapped write", 32'h0000_0007, q);
    bus(1'b0, 8'h80, 8'h00);
    chk("unmapped read", 32'h0000_0000, q);
    bus(1'b0, 8'h44, 8'h00);
    chk("paged read", 32'h0000_005a, q);
    chk("paged read route", 32'h0000_7100, {16'h0000, mq});
    bus(1'b1, 8'h00, 8'h02);
    bus(1'b1, 8'h48, 8'h3c);
    chk("paged write", 32'h0000_a23c, {16'h0000, mq});
    mod_rd <= 8'ha5;
    bus(1'b0, 8'h7c, 8'h00);
    chk("paged read page 2", 32'h0000_00a5, q);
    chk("paged read page 2 route", 32'h0000_2f00, {16'h0000, mq});
    $display("paged access done");
    rst_n_i <= 1'b0;
    repeat (2) @(posedge sys_clk_i);
    rst_n_i <= 1'b1;
    bus(1'b0, 8'h00, 8'h00);
    chk("second reset", 32'h0000_0000, q);
    chk("second reset page_o", 32'h0000_0000, {29'h0000_0000, pg_o});
    $display("mid-run reset done");
    test_done();
  end
endmodule
bind bank_select bank_select_assertions u_chk (.*);
